// file: reset_initial_conditions.sv
// Reset-cause flags and per-reset-type register initial values
// Operation
// - Keep timeout and powerdown flags, updated by halt entry and watchdog.
// - Power-on reset clears both flags.
// - Low-voltage reset in run mode leaves both flags unchanged.
// - Watchdog reset in run mode sets timeout, keeps powerdown.
// - Watchdog reset in halt mode sets both flags.
// - Power-on reset disables all interrupts.
// - Power-on clears the watchdog counter; watchdog then counts.
// - Power-on reset turns the timer module off.
// - Power-on reset makes every I/O line an input.
// - Power-on reset sets the stack pointer to the stack top.
// - Full resets load port ones and watchdog control 0101 0011.
// - Pointers and accumulator unchanged by watchdog resets.
// - Program counter low byte clears on every reset type.
// - Power-on reset clears the program counter.
// - Watchdog reset in halt touches only program counter low byte, stack, flags and last reset kind.
`default_nettype none
module reset_initial_conditions
  import reset_cond_pkg::*;
(
  input  wire logic       MCLK,
  input  wire logic       RST,
  input  wire logic       POR_REQ,
  input  wire logic       LOW_VOLTAGE_RESET,
  input  wire logic       WATCHDOG_TIMEOUT,
  input  wire logic       HALT_MODE,
  input  wire logic       HALT_ENTER,
  input  wire logic       WATCHDOG_CLEAR,
  input  wire logic       REG_WR,
  input  wire logic [2:0] REG_SEL,
  input  wire logic [7:0] REG_WDATA,
  output logic            TIMEOUT_FLAG,
  output logic            POWERDOWN_FLAG,
  output logic [7:0]      PROGRAM_COUNTER_LOW,
  output logic [2:0]      STACK_POINTER,
  output logic [7:0]      INT_ENABLE,
  output logic [7:0]      WATCHDOG_COUNT,
  output logic            TIMER_ON,
  output logic [7:0]      PORT_A_DATA,
  output logic [7:0]      PORT_A_DIRECTION,
  output logic [7:0]      WATCHDOG_CONTROL,
  output logic [7:0]      ACCUMULATOR,
  output logic [7:0]      MEMORY_POINTER_ZERO,
  output logic [7:0]      TABLE_POINTER,
  output logic [2:0]      LAST_RESET_KIND
);
  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge MCLK) begin
    sync1_q <= {POR_REQ, LOW_VOLTAGE_RESET, WATCHDOG_TIMEOUT, HALT_MODE};
    sync2_q <= sync1_q;
  end
  wire por_s  = sync2_q[3];
  wire lvr_s  = sync2_q[2];
  wire wdt_s  = sync2_q[1];
  wire halt_s = sync2_q[0];

  // ----------------------------------------------------------------
  // Reset type decode
  // ----------------------------------------------------------------
  wire por_ev   = RST | por_s;
  wire lvr_ev   = ~por_ev & lvr_s & ~halt_s;
  wire wdrun_ev = ~por_ev & ~lvr_s & wdt_s & ~halt_s;
  wire wdhlt_ev = ~por_ev & ~lvr_s & wdt_s & halt_s;
  // Full reset loads defined register values
  wire full_ev  = por_ev | lvr_ev | wdrun_ev;
  wire any_ev   = full_ev | wdhlt_ev;

  // ----------------------------------------------------------------
  // Reset-cause flags
  // ----------------------------------------------------------------
  logic to_q;
  logic to_d;
  logic pd_q;
  logic pd_d;
  always_comb begin
    to_d = to_q;
    pd_d = pd_q;
    if (por_ev) begin
      to_d = 1'b0;
      pd_d = 1'b0;
    end else if (wdhlt_ev) begin
      to_d = 1'b1;
      pd_d = 1'b1;
    end else if (wdrun_ev) begin
      to_d = 1'b1;
    end else if (lvr_ev) begin
      to_d = to_q;
    end else if (HALT_ENTER) begin
      to_d = 1'b0;
      pd_d = 1'b1;
    end else if (WATCHDOG_CLEAR) begin
      to_d = 1'b0;
      pd_d = 1'b0;
    end
  end
  always_ff @(posedge MCLK) begin
    to_q <= to_d;
    pd_q <= pd_d;
  end

  // ----------------------------------------------------------------
  // Program counter, stack, control state
  // ----------------------------------------------------------------
  logic [7:0] pcl_q;
  logic [2:0] sp_q;
  logic [7:0] inten_q;
  logic [7:0] wdcnt_q;
  logic       tmr_q;
  wire wr_pcl = REG_WR & (REG_SEL == 3'h0);
  wire wr_int = REG_WR & (REG_SEL == 3'h1);
  wire wr_tmr = REG_WR & (REG_SEL == 3'h2);
  always_ff @(posedge MCLK) begin
    if (any_ev) begin
      pcl_q <= PCL_RESET_VAL;
      sp_q  <= STACK_TOP;
    end else if (wr_pcl) begin
      pcl_q <= REG_WDATA;
    end
  end
  always_ff @(posedge MCLK) begin
    if (full_ev) begin
      inten_q <= INT_OFF_VAL;
      tmr_q   <= 1'b0;
    end else begin
      if (wr_int) begin
        inten_q <= REG_WDATA;
      end
      if (wr_tmr) begin
        tmr_q <= REG_WDATA[0];
      end
    end
  end
  // Watchdog restarts from zero and counts straight away
  always_ff @(posedge MCLK) begin
    if (full_ev || WATCHDOG_CLEAR || HALT_ENTER) begin
      wdcnt_q <= WD_COUNT_ZERO;
    end else begin
      wdcnt_q <= wdcnt_q + WD_COUNT_ONE;
    end
  end

  // ----------------------------------------------------------------
  // Port and watchdog control registers
  // ----------------------------------------------------------------
  logic [7:0] pa_v;
  logic [7:0] pac_v;
  logic [7:0] wdc_v;
  hold_reg #(.INIT(PORT_RESET_VAL)) u_pa (
    .clk       (MCLK),
    .load_init (full_ev),
    .wr_en     (REG_WR & (REG_SEL == 3'h3)),
    .wr_data   (REG_WDATA),
    .value     (pa_v)
  );
  hold_reg #(.INIT(PORT_RESET_VAL)) u_pac (
    .clk       (MCLK),
    .load_init (full_ev),
    .wr_en     (REG_WR & (REG_SEL == 3'h4)),
    .wr_data   (REG_WDATA),
    .value     (pac_v)
  );
  hold_reg #(.INIT(WDCTRL_RESET_VAL)) u_wdc (
    .clk       (MCLK),
    .load_init (full_ev),
    .wr_en     (REG_WR & (REG_SEL == 3'h5)),
    .wr_data   (REG_WDATA),
    .value     (wdc_v)
  );

  // ----------------------------------------------------------------
  // Data registers with no reset value
  // ----------------------------------------------------------------
  logic [7:0] acc_q;
  logic [7:0] mp_q;
  logic [7:0] table_pointer_q;
  // Written only by software; every reset leaves them alone
  always_ff @(posedge MCLK) begin
    if (REG_WR && (REG_SEL == 3'h6)) begin
      acc_q <= REG_WDATA;
    end
    if (REG_WR && (REG_SEL == 3'h7)) begin
      mp_q   <= REG_WDATA;
      table_pointer_q <= ~REG_WDATA;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  logic [2:0] kind_q;
  always_ff @(posedge MCLK) begin
    TIMEOUT_FLAG        <= to_q;
    POWERDOWN_FLAG      <= pd_q;
    PROGRAM_COUNTER_LOW <= pcl_q;
    STACK_POINTER       <= sp_q;
    INT_ENABLE          <= inten_q;
    WATCHDOG_COUNT      <= wdcnt_q;
    TIMER_ON            <= tmr_q;
    PORT_A_DATA         <= pa_v;
    PORT_A_DIRECTION    <= pac_v;
    WATCHDOG_CONTROL    <= wdc_v;
    ACCUMULATOR         <= acc_q;
    MEMORY_POINTER_ZERO <= mp_q;
    TABLE_POINTER       <= table_pointer_q;
    LAST_RESET_KIND     <= kind_q;
    if (por_ev) begin
      kind_q <= 3'h1;
    end else if (lvr_ev) begin
      kind_q <= 3'h2;
    end else if (wdrun_ev) begin
      kind_q <= 3'h3;
    end else if (wdhlt_ev) begin
      kind_q <= 3'h4;
    end
  end
endmodule // reset_initial_conditions
`default_nettype wire

// file: reset_cond_pkg.sv
// Constants for the reset initial-conditions block
`default_nettype none
package reset_cond_pkg;
  localparam logic [7:0] PORT_RESET_VAL   = 8'hff;
  localparam logic [7:0] WDCTRL_RESET_VAL = 8'h53;
  localparam logic [7:0] PCL_RESET_VAL    = 8'h00;
  localparam logic [7:0] ZERO_BYTE        = 8'h00;
  localparam logic [7:0] INT_OFF_VAL      = 8'h00;
  localparam logic [2:0] STACK_TOP        = 3'h0;
  localparam logic [7:0] WD_COUNT_ZERO    = 8'h00;
  localparam logic [7:0] WD_COUNT_ONE     = 8'h01;
  localparam int         REG_W            = 8;
  typedef enum logic [1:0] {
    KIND_NONE,
    KIND_FULL,
    KIND_WAKE
  } reset_kind_t;
endpackage : reset_cond_pkg
`default_nettype wire

// file: hold_reg.sv
// Register that loads a reset value, a write value, or holds
`default_nettype none
module hold_reg
  import reset_cond_pkg::*;
#(
  parameter logic [REG_W-1:0] INIT = 8'h00
) (
  input  wire logic             clk,
  input  wire logic             load_init,
  input  wire logic             wr_en,
  input  wire logic [REG_W-1:0] wr_data,
  output var  logic [REG_W-1:0] value
);
  // Unchanged bits simply hold; no transient clear
  always_ff @(posedge clk) begin
    if (load_init) begin
      value <= INIT;
    end else if (wr_en) begin
      value <= wr_data;
    end
  end
endmodule // hold_reg
`default_nettype wire

// file: reset_cond_monitor.sv
// Assertion checker for the reset initial-conditions block
`default_nettype none
module reset_cond_monitor
  import reset_cond_pkg::*;
(
  input wire logic       MCLK,
  input wire logic       RST,
  input wire logic       POR_REQ,
  input wire logic       LOW_VOLTAGE_RESET,
  input wire logic       WATCHDOG_TIMEOUT,
  input wire logic       HALT_MODE,
  input wire logic       HALT_ENTER,
  input wire logic       WATCHDOG_CLEAR,
  input wire logic       REG_WR,
  input wire logic       TIMEOUT_FLAG,
  input wire logic       POWERDOWN_FLAG,
  input wire logic [7:0] PROGRAM_COUNTER_LOW,
  input wire logic [2:0] STACK_POINTER,
  input wire logic [7:0] INT_ENABLE,
  input wire logic [7:0] WATCHDOG_COUNT,
  input wire logic       TIMER_ON,
  input wire logic [7:0] PORT_A_DATA,
  input wire logic [7:0] PORT_A_DIRECTION,
  input wire logic [7:0] WATCHDOG_CONTROL,
  input wire logic [7:0] ACCUMULATOR,
  input wire logic [7:0] MEMORY_POINTER_ZERO
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_quiet;
    (!HALT_ENTER && !WATCHDOG_CLEAR && !WATCHDOG_TIMEOUT && !POR_REQ)[*6];
  endsequence
  sequence s_wd_halt;
    (WATCHDOG_TIMEOUT && HALT_MODE && !POR_REQ && !REG_WR)[*2];
  endsequence
  sequence s_wd_run;
    (WATCHDOG_TIMEOUT && !HALT_MODE && !POR_REQ && !LOW_VOLTAGE_RESET)[*2];
  endsequence
  a_por_flags_clear: assert property ($fell(RST) |-> ##[0:3]
    (!TIMEOUT_FLAG && !POWERDOWN_FLAG)) else $error("flags not cleared");
  a_por_outputs_off: assert property ($fell(RST) |-> ##[0:3]
    (INT_ENABLE == INT_OFF_VAL && !TIMER_ON)) else $error("not disabled");
  a_por_ports_in: assert property ($fell(RST) |-> ##[0:3]
    (PORT_A_DIRECTION == PORT_RESET_VAL && PORT_A_DATA == PORT_RESET_VAL))
    else $error("ports not inputs");
  a_por_stack_top: assert property ($fell(RST) |-> ##[0:3]
    (STACK_POINTER == STACK_TOP && PROGRAM_COUNTER_LOW == PCL_RESET_VAL))
    else $error("stack or counter not reset");
  a_por_wd_clear: assert property ($fell(RST) |->
    WATCHDOG_COUNT <= WD_COUNT_ONE) else $error("watchdog not cleared");
  a_wd_halt_flags: assert property (s_wd_halt |-> ##[1:5]
    (TIMEOUT_FLAG && POWERDOWN_FLAG && PROGRAM_COUNTER_LOW == PCL_RESET_VAL
     && STACK_POINTER == STACK_TOP)) else $error("halt watchdog wrong");
  a_wd_run_load: assert property (s_wd_run |-> ##[1:5]
    (TIMEOUT_FLAG && WATCHDOG_CONTROL == WDCTRL_RESET_VAL))
    else $error("run watchdog wrong");
  a_lvr_keeps_flags: assert property (s_quiet ##0 LOW_VOLTAGE_RESET |->
    ($stable(TIMEOUT_FLAG) && $stable(POWERDOWN_FLAG))[*6])
    else $error("flags changed on low voltage");
  a_wd_keeps_ptrs: assert property ((WATCHDOG_TIMEOUT && !REG_WR)[*2] |->
    $stable(ACCUMULATOR) && $stable(MEMORY_POINTER_ZERO))
    else $error("pointers changed on watchdog");
endmodule // reset_cond_monitor
bind reset_initial_conditions reset_cond_monitor mon (.*);
`default_nettype wire

// file: reset_initial_conditions_tb_top.sv
// Self-checking testbench for the reset initial-conditions block
`default_nettype none
module reset_initial_conditions_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import reset_cond_pkg::*;
  logic MCLK, RST, POR_REQ, LOW_VOLTAGE_RESET, WATCHDOG_TIMEOUT, HALT_MODE;
  logic HALT_ENTER, WATCHDOG_CLEAR, REG_WR, TIMEOUT_FLAG, POWERDOWN_FLAG;
  logic TIMER_ON;
  logic [2:0] REG_SEL, STACK_POINTER, LAST_RESET_KIND;
  logic [7:0] REG_WDATA, PROGRAM_COUNTER_LOW, INT_ENABLE, WATCHDOG_COUNT;
  logic [7:0] PORT_A_DATA, PORT_A_DIRECTION, WATCHDOG_CONTROL, ACCUMULATOR;
  logic [7:0] MEMORY_POINTER_ZERO, TABLE_POINTER;
  int failures = 0;
  int n_compared = 0;
  reset_initial_conditions dut (.*);
  // ------------------------------
  // Helpers
  // ------------------------------
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tick(int n);
    repeat (n) @(negedge MCLK);
  endtask
  task automatic wr(logic [2:0] s, logic [7:0] d);
    REG_SEL = s;
    REG_WDATA = d;
    REG_WR = 1'b1;
    tick(1);
    REG_WR = 1'b0;
  endtask
  // Raise a source for n cycles, then let it settle through the syncs
  task automatic hold(ref logic s, input int n);
    s = 1'b1;
    tick(n);
    s = 1'b0;
    tick(8);
  endtask
  task automatic chk_flags(logic [1:0] e);
    chk("flags", 8'(e), 8'({TIMEOUT_FLAG, POWERDOWN_FLAG}));
  endtask
  task automatic t_por(input logic [7:0] wd_exp);
    chk_flags(2'b00);
    chk("wd_count", wd_exp, WATCHDOG_COUNT);
    chk("kind", 8'h01, 8'(LAST_RESET_KIND));
    chk("int_enable", INT_OFF_VAL, INT_ENABLE);
    chk("timer_on", 8'h00, 8'(TIMER_ON));
    chk("port_dir", PORT_RESET_VAL, PORT_A_DIRECTION);
    chk("port_data", PORT_RESET_VAL, PORT_A_DATA);
    chk("wd_ctrl", WDCTRL_RESET_VAL, WATCHDOG_CONTROL);
    chk("stack", 8'(STACK_TOP), 8'(STACK_POINTER));
    chk("pcl", PCL_RESET_VAL, PROGRAM_COUNTER_LOW);
    $display("test por done");
  endtask
  task automatic t_wd_halt;
    wr(3'h6, 8'h5a);
    wr(3'h7, 8'h3c);
    wr(3'h4, 8'h0f);
    wr(3'h0, 8'h12);
    hold(HALT_ENTER, 1);
    HALT_MODE = 1'b1;
    hold(WATCHDOG_TIMEOUT, 2);
    chk_flags(2'b11);
    chk("pcl", PCL_RESET_VAL, PROGRAM_COUNTER_LOW);
    chk("stack", 8'(STACK_TOP), 8'(STACK_POINTER));
    chk("acc", 8'h5a, ACCUMULATOR);
    chk("memptr", 8'h3c, MEMORY_POINTER_ZERO);
    chk("tblptr", 8'hc3, TABLE_POINTER);
    chk("kind", 8'h04, 8'(LAST_RESET_KIND));
    chk("port_dir", 8'h0f, PORT_A_DIRECTION);
    $display("test watchdog in halt done");
  endtask
  task automatic t_lvr;
    HALT_MODE = 1'b0;
    tick(4);
    hold(WATCHDOG_CLEAR, 1);
    hold(HALT_ENTER, 1);
    wr(3'h4, 8'h0f);
    hold(LOW_VOLTAGE_RESET, 3);
    chk_flags(2'b01);
    chk("acc", 8'h5a, ACCUMULATOR);
    chk("kind", 8'h02, 8'(LAST_RESET_KIND));
    $display("test low voltage done");
  endtask
  task automatic t_wd_run;
    wr(3'h4, 8'h0f);
    hold(WATCHDOG_TIMEOUT, 2);
    chk_flags(2'b11);
    chk("port_dir", PORT_RESET_VAL, PORT_A_DIRECTION);
    chk("wd_ctrl", WDCTRL_RESET_VAL, WATCHDOG_CONTROL);
    chk("acc", 8'h5a, ACCUMULATOR);
    chk("kind", 8'h03, 8'(LAST_RESET_KIND));
    $display("test watchdog in run done");
  endtask
  task automatic finish_test;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  initial begin
    {POR_REQ, LOW_VOLTAGE_RESET, WATCHDOG_TIMEOUT, HALT_MODE} = 4'h0;
    {HALT_ENTER, WATCHDOG_CLEAR, REG_WR, REG_SEL, REG_WDATA} = 14'h0000;
    RST = 1'b1;
    tick(8);
    RST = 1'b0;
    tick(3);
    t_por(8'h02);
    t_wd_halt;
    t_lvr;
    t_wd_run;
    hold(POR_REQ, 2);
    t_por(8'h05);
    finish_test;
  end
  initial begin
    #20us;
    failures++;
    finish_test;
  end
endmodule // reset_initial_conditions_tb_top
`default_nettype wire
